// [verilog/sram_port_regs.svh]
// constants for the two-word burst sram port core
`ifndef SRAM_PORT_REGS_SVH
`define SRAM_PORT_REGS_SVH

// ************************************************************
// widths and organisation
// ************************************************************
`define ADDR_W        19
`define WORD_W        18
`define BYTE_W        9
`define BURST_W       36
`define ARRAY_DEPTH   524288
`define BYTE_LANES    4

// ************************************************************
// timing
// ************************************************************
`define CLK_FREQ_MHZ  200
`define PLL_LOCK_US   20
`define LOCK_CNT_W    12

// ************************************************************
// read pipeline stages (index into start delay line)
// ************************************************************
`define LEGACY_W0_STAGE 1
`define PLL_W0_STAGE    2
`define DLY_W           4

`endif

// [verilog/sram_port_pkg.sv]
// types shared by the sram port core
package sram_port_pkg;

	typedef enum logic [1:0] {
		LINK_IDLE,
		LINK_WAIT,
		LINK_WORD0,
		LINK_WORD1
	} link_state_e;

endpackage

// [verilog/dual_array_mem.sv]
// two storage arrays with byte-masked write and registered read
`timescale 1ns/100ps
`include "sram_port_regs.svh"

module dual_array_mem (
	// clock
	input  wire logic                   clk,
	// write side
	input  wire logic                   wrEn,
	input  wire logic [`ADDR_W-1:0]     wrAddr,
	input  wire logic [`WORD_W-1:0]     wrLo,
	input  wire logic [`WORD_W-1:0]     wrHi,
	input  wire logic [`BYTE_LANES-1:0] wrByteN,
	// read side
	input  wire logic                   rdEn,
	input  wire logic [`ADDR_W-1:0]     rdAddr,
	output logic      [`WORD_W-1:0]     rdLo,
	output logic      [`WORD_W-1:0]     rdHi
);

	logic [`WORD_W-1:0] arrayLo [0:`ARRAY_DEPTH-1];
	logic [`WORD_W-1:0] arrayHi [0:`ARRAY_DEPTH-1];

	// keeps each byte whose select is high (inactive)
	function automatic logic [`WORD_W-1:0] mergeWord(
		input logic [`WORD_W-1:0] oldWord,
		input logic [`WORD_W-1:0] newWord,
		input logic [1:0]         byteN);
		logic [`WORD_W-1:0] res;
		res = oldWord;
		if (!byteN[0]) begin
			res[`BYTE_W-1:0] = newWord[`BYTE_W-1:0];
		end
		if (!byteN[1]) begin
			res[`WORD_W-1:`BYTE_W] = newWord[`WORD_W-1:`BYTE_W];
		end
		return res;
	endfunction

	wire logic [`WORD_W-1:0] mergedLo = mergeWord(arrayLo[wrAddr], wrLo, wrByteN[1:0]);
	wire logic [`WORD_W-1:0] mergedHi = mergeWord(arrayHi[wrAddr], wrHi, wrByteN[3:2]);

	always_ff @(posedge clk) begin
		if (wrEn) begin
			arrayLo[wrAddr] <= mergedLo;
			arrayHi[wrAddr] <= mergedHi;
		end
	end

	always_ff @(posedge clk) begin
		if (rdEn) begin
			rdLo <= arrayLo[rdAddr];
			rdHi <= arrayHi[rdAddr];
		end
	end

endmodule

// [verilog/ddr_sram_read_port.sv]
// device core of a two-word burst sram with split read and write ports
`timescale 1ns/100ps
`include "sram_port_regs.svh"
// Function
// R1: write data enters only through the write port and read data leaves only through the read port.
// R2: reads and writes share one address bus, read address on the positive slot, write on the negative.
// R3: every access moves exactly two words of the configured width within one input clock period; two-clock mode drops a read while the link is busy.
// R4: with the pll enabled, read data starts one and a half input clock periods after initiation.
// R5: with the pll disabled, read data starts one input clock period after initiation.
// R6: accesses on both ports start only on the positive input clock slot.
// R7: write data is captured in input registers on both slots of the input clock pair.
// R8: read data leaves from output registers on the output reference clock, or the input clock in single-clock mode.
// R9: port selects and byte selects are registered on the input clock before they act.
// R10: storage is two arrays of 512K by 18 and each access is a burst of two sequential words.
// R11: a read starts when the read select is low on the positive slot and that address is stored.
// R12: after the next positive edge the lowest-order word of the burst is driven.
// R13: on the following output edge the second word of the burst is driven.
// R14: after the burst the read data output returns to high impedance with no wait state needed.
// R15: the far side ties both output reference clocks high at power-on to pick single-clock mode.
// R16: with the pll enabled the device is ready 20 us after a stable clock.
// R17: a read select sampled high starts no read and leaves the output in high impedance.

module ddr_sram_read_port (
	// core clock and reset
	input  wire logic                 clk,
	input  wire logic                 rstn,
	// output reference clock
	input  wire logic                 outRefClk,
	// straps
	input  wire logic                 pllDisableN,
	input  wire logic                 singleClockTie,
	// address and selects
	input  wire logic [`ADDR_W-1:0]   address,
	input  wire logic                 readPortSelectN,
	input  wire logic                 writePortSelectN,
	input  wire logic [1:0]           byteWriteSelectN,
	// write port
	input  wire logic [`WORD_W-1:0]   writeData,
	// read port
	output logic      [`WORD_W-1:0]   readDataOut,
	output logic                      readDataOe,
	// status
	output logic                      pllReady
);

	localparam int LOCK_CYC = `PLL_LOCK_US * `CLK_FREQ_MHZ;
	localparam logic [`LOCK_CNT_W-1:0] LOCK_LAST = `LOCK_CNT_W'(LOCK_CYC - 1);

	// ************************************************************
	// straps and pll lock
	// ************************************************************
	logic                   pllSync1;
	logic                   pllMode;
	logic                   tieSync1;
	logic                   tieSync2;
	logic                   strapArm1;
	logic                   strapArm2;
	logic                   strapDone;
	logic                   singleClk;
	logic [`LOCK_CNT_W-1:0] lockCnt;
	logic                   locked;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pllSync1 <= 1'h0;
			pllMode  <= 1'h0;
			tieSync1 <= 1'h0;
			tieSync2 <= 1'h0;
			strapArm1 <= 1'h0;
			strapArm2 <= 1'h0;
		end else begin
			pllSync1 <= pllDisableN;
			pllMode  <= pllSync1;
			tieSync1 <= singleClockTie;
			tieSync2 <= tieSync1;
			strapArm1 <= 1'h1;
			strapArm2 <= strapArm1;
		end
	end

	// strap is caught once both sync stages hold the pin, then held
	always_ff @(posedge clk) begin
		if (!rstn) begin
			strapDone <= 1'h0;
			singleClk <= 1'h0;
		end else if (!strapDone && strapArm2) begin
			strapDone <= 1'h1;
			singleClk <= tieSync2; // R15
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || !pllMode) begin
			lockCnt <= '0;
			locked  <= 1'h0;
		end else if (!locked) begin
			lockCnt <= lockCnt + `LOCK_CNT_W'(1);
			locked  <= (lockCnt == LOCK_LAST); // R16
		end
	end

	assign pllReady = strapDone && (!pllMode || locked); // R16

	// ************************************************************
	// input clock slots and input registers
	// ************************************************************
	logic                 negSlot;
	logic                 wrPend;
	logic [`WORD_W-1:0]   wrLoReg;
	logic [1:0]           wrBwLoReg;
	logic [`ADDR_W-1:0]   rdAddrReg;
	logic [`DLY_W-1:0]    startDly;

	wire logic start   = !negSlot && !readPortSelectN && pllReady; // R6 R11 R17
	wire logic wrStart = !negSlot && !writePortSelectN && pllReady; // R6
	wire logic wrCommit = negSlot && wrPend; // R2 R7

	always_ff @(posedge clk) begin
		if (!rstn) begin
			negSlot  <= 1'h0;
			wrPend   <= 1'h0;
			startDly <= '0;
		end else begin
			negSlot  <= !negSlot;
			wrPend   <= wrStart; // R9
			startDly <= {startDly[`DLY_W-2:0], start}; // R9
		end
	end

	// first word and its byte selects taken on the positive slot
	always_ff @(posedge clk) begin
		if (wrStart) begin
			wrLoReg   <= writeData; // R7
			wrBwLoReg <= byteWriteSelectN; // R9
		end
		if (start) begin
			rdAddrReg <= address; // R11
		end
	end

	// ************************************************************
	// storage
	// ************************************************************
	logic [`WORD_W-1:0] memLo;
	logic [`WORD_W-1:0] memHi;

	dual_array_mem u_mem (
		.clk     (clk),
		.wrEn    (wrCommit), // R1 R10
		.wrAddr  (address),
		.wrLo    (wrLoReg),
		.wrHi    (writeData),
		.wrByteN ({byteWriteSelectN, wrBwLoReg}),
		.rdEn    (start),
		.rdAddr  (address),
		.rdLo    (memLo),
		.rdHi    (memHi)
	);

	// ************************************************************
	// single-clock output path
	// ************************************************************
	logic [`BURST_W-1:0] pipe1;
	logic [`BURST_W-1:0] pipe2;
	logic [`BURST_W-1:0] pipe3;
	logic [`WORD_W-1:0]  kQ;
	logic                kOe;

	always_ff @(posedge clk) begin
		pipe1 <= {memHi, memLo};
		pipe2 <= pipe1;
		pipe3 <= pipe2;
	end

	wire logic wordLoSel = pllMode ? startDly[`PLL_W0_STAGE] : startDly[`LEGACY_W0_STAGE]; // R4 R5
	wire logic wordHiSel = pllMode ? startDly[`PLL_W0_STAGE+1]
		: startDly[`LEGACY_W0_STAGE+1]; // R3 R13
	wire logic [`WORD_W-1:0] word0 = pllMode ? pipe2[`WORD_W-1:0] : pipe1[`WORD_W-1:0]; // R12
	wire logic [`WORD_W-1:0] word1 = pllMode ? pipe3[`BURST_W-1:`WORD_W]
		: pipe2[`BURST_W-1:`WORD_W]; // R10
	wire logic [`WORD_W-1:0] next_kQ = wordLoSel ? word0 : (wordHiSel ? word1 : kQ);
	wire logic next_kOe = wordLoSel || wordHiSel; // R14 R17

	always_ff @(posedge clk) begin
		if (!rstn) begin
			kQ  <= '0;
			kOe <= 1'h0;
		end else begin
			kQ  <= next_kQ; // R8
			kOe <= next_kOe; // R14
		end
	end

	// ************************************************************
	// hand-off toward the output reference clock
	// ************************************************************
	logic                reqToggle;
	logic [`BURST_W-1:0] reqData;
	logic                ackSync1;
	logic                ackSync2;
	logic                ackToggle;

	// a burst arriving while the previous one is still owned is dropped
	wire logic linkBusy = reqToggle != ackSync2;
	wire logic sendBurst = startDly[0] && !singleClk && !linkBusy;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			reqToggle <= 1'h0;
			ackSync1  <= 1'h0;
			ackSync2  <= 1'h0;
		end else begin
			ackSync1 <= ackToggle;
			ackSync2 <= ackSync1;
			if (sendBurst) begin
				reqToggle <= !reqToggle;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sendBurst) begin
			reqData <= {memHi, memLo};
		end
	end

	// ************************************************************
	// output reference clock domain
	// ************************************************************
	logic                         linkRst1;
	logic                         linkRstn;
	logic                         reqSync1;
	logic                         reqSync2;
	logic                         pllSyncL1;
	logic                         pllL;
	logic [`BURST_W-1:0]          linkData;
	logic [`WORD_W-1:0]           cQ;
	logic                         cOe;
	sram_port_pkg::link_state_e   linkState;
	sram_port_pkg::link_state_e   next_linkState;

	// level compare so a request arriving mid-burst waits instead of being lost
	wire logic newReq = reqSync2 != ackToggle;

	always_ff @(posedge outRefClk) begin
		linkRst1  <= rstn;
		linkRstn  <= linkRst1;
		reqSync1  <= reqToggle;
		reqSync2  <= reqSync1;
		pllSyncL1 <= pllMode;
		pllL      <= pllSyncL1;
	end

	always_comb begin
		case (linkState)
			sram_port_pkg::LINK_IDLE: begin
				if (newReq && pllL) begin
					next_linkState = sram_port_pkg::LINK_WAIT; // R4
				end else if (newReq) begin
					next_linkState = sram_port_pkg::LINK_WORD0; // R5
				end else begin
					next_linkState = sram_port_pkg::LINK_IDLE;
				end
			end
			sram_port_pkg::LINK_WAIT:  next_linkState = sram_port_pkg::LINK_WORD0;
			sram_port_pkg::LINK_WORD0: next_linkState = sram_port_pkg::LINK_WORD1; // R13
			sram_port_pkg::LINK_WORD1: next_linkState = sram_port_pkg::LINK_IDLE; // R14
			default:                   next_linkState = sram_port_pkg::LINK_IDLE;
		endcase
	end

	wire logic linkLoad = linkState == sram_port_pkg::LINK_IDLE && newReq;
	wire logic driveLo = next_linkState == sram_port_pkg::LINK_WORD0;
	wire logic driveHi = next_linkState == sram_port_pkg::LINK_WORD1;
	wire logic [`BURST_W-1:0] burstSrc = linkLoad ? reqData : linkData;

	always_ff @(posedge outRefClk) begin
		if (!linkRstn) begin
			linkState <= sram_port_pkg::LINK_IDLE;
			ackToggle <= 1'h0;
			cQ        <= '0;
			cOe       <= 1'h0;
		end else begin
			linkState <= next_linkState;
			if (linkLoad) begin
				ackToggle <= reqSync2;
			end
			if (driveLo) begin
				cQ <= burstSrc[`WORD_W-1:0]; // R8 R12
			end else if (driveHi) begin
				cQ <= burstSrc[`BURST_W-1:`WORD_W]; // R13
			end
			cOe <= driveLo || driveHi; // R14
		end
	end

	always_ff @(posedge outRefClk) begin
		if (linkLoad) begin
			linkData <= reqData;
		end
	end

	// ************************************************************
	// read port pins
	// ************************************************************
	assign readDataOut = singleClk ? kQ : cQ; // R1 R8
	assign readDataOe  = singleClk ? kOe : (cOe && strapDone);

	// ************************************************************
	// checks
	// ************************************************************
	sequence s_legacyStart;
		start && !pllMode;
	endsequence

	sequence s_pllStart;
		start && pllMode;
	endsequence

	property p_legacy_burst;
		@(posedge clk) disable iff (!rstn)
		s_legacyStart |-> ##3 (kOe && kQ == $past(memLo, 2)) ##1 (kOe && kQ == $past(memHi, 3));
	endproperty
	a_legacy_burst: assert property (p_legacy_burst) else $error("legacy burst timing"); // R5

	property p_pll_burst;
		@(posedge clk) disable iff (!rstn)
		s_pllStart |-> ##4 (kOe && kQ == $past(memLo, 3)) ##1 (kOe && kQ == $past(memHi, 4));
	endproperty
	a_pll_burst: assert property (p_pll_burst) else $error("pll burst timing"); // R4

	property p_legacy_hiz;
		@(posedge clk) disable iff (!rstn)
		s_legacyStart ##2 !start |-> ##3 !kOe;
	endproperty
	a_legacy_hiz: assert property (p_legacy_hiz) else $error("output not released"); // R14

	property p_idle_hiz;
		@(posedge clk) disable iff (!rstn)
		(!pllMode && $stable(pllMode) && !$past(start, 3) && !$past(start, 4)) |-> !kOe;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz) else $error("output driven without read"); // R17

	property p_slot_alternate;
		@(posedge clk) disable iff (!rstn)
		(start || wrStart) |=> !start && !wrStart;
	endproperty
	a_slot_alternate: assert property (p_slot_alternate) else $error("access on negative slot"); // R6

	property p_read_addr;
		@(posedge clk) disable iff (!rstn)
		start |=> rdAddrReg == $past(address) && startDly[0];
	endproperty
	a_read_addr: assert property (p_read_addr) else $error("read address not held"); // R11

	property p_write_pair;
		@(posedge clk) disable iff (!rstn)
		wrStart |=> wrCommit && wrLoReg == $past(writeData);
	endproperty
	a_write_pair: assert property (p_write_pair) else $error("write pair not committed"); // R7

	property p_not_ready;
		@(posedge clk) disable iff (!rstn)
		!pllReady |=> startDly[0] == 1'h0;
	endproperty
	a_not_ready: assert property (p_not_ready) else $error("read before pll ready"); // R16

	property p_link_burst;
		@(posedge outRefClk) disable iff (!linkRstn)
		$rose(cOe) |=> cOe ##1 !cOe;
	endproperty
	a_link_burst: assert property (p_link_burst) else $error("link burst length"); // R3

endmodule

// [testbench/ctrl_model.sv]
// far-side memory controller model driving selects, address and write data
`timescale 1ns/100ps
`include "sram_port_regs.svh"

module ctrl_model (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// controller outputs
	output logic      [`ADDR_W-1:0] address,
	output logic                    readPortSelectN,
	output logic                    writePortSelectN,
	output logic      [1:0]         byteWriteSelectN,
	output logic      [`WORD_W-1:0] writeData
);
	logic [`BURST_W-1:0] refMem [int];
	logic [`WORD_W-1:0]  expData [$];
	int                  expCyc [$];
	int                  cyc = 0;
	int                  lat = 3;
	logic                nextPos = 1'b1;
	logic [15:0]         seed = 16'hEE3E;

	// ********
	// slot tracking
	// ********
	always @(posedge clk) begin
		cyc <= cyc + 1;
		nextPos <= !rstn || !nextPos;
	end

	// ********
	// helpers
	// ********
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction

	task automatic step();
		seed = lfsr(seed);
	endtask

	// idle lines change after each read so a stale value never passes
	task automatic scramble();
		step();
		address = {seed[2:0], seed};
		writeData = {seed[1:0], ~seed};
	endtask

	task automatic waitPos();
		@(negedge clk);
		while (!nextPos) @(negedge clk);
	endtask

	// ********
	// transfers
	// ********
	task automatic writeBurst(input logic [`ADDR_W-1:0] a, input logic [`BURST_W-1:0] d,
		input logic [3:0] bwN);
		waitPos();
		writePortSelectN = 1'b0;
		writeData = d[17:0];
		byteWriteSelectN = bwN[1:0];
		@(negedge clk);
		writePortSelectN = 1'b1;
		address = a;
		writeData = d[35:18];
		byteWriteSelectN = bwN[3:2];
		for (int i = 0; i < 4; i++) if (!bwN[i]) refMem[a][i*9 +: 9] = d[i*9 +: 9];
	endtask

	task automatic readBurst(input logic [`ADDR_W-1:0] a);
		waitPos();
		readPortSelectN = 1'b0;
		address = a;
		expData.push_back(refMem[a][17:0]);
		expData.push_back(refMem[a][35:18]);
		expCyc.push_back(lat < 0 ? -1 : cyc + lat);
		expCyc.push_back(lat < 0 ? -1 : cyc + 1 + lat);
		@(negedge clk);
		readPortSelectN = 1'b1;
		scramble();
	endtask

	initial begin
		readPortSelectN = 1'b1;
		writePortSelectN = 1'b1;
		byteWriteSelectN = 2'b11;
		scramble();
	end
endmodule

// [testbench/ddr_sram_read_port_tb.sv]
// self-checking bench for the two-word burst sram port core
`timescale 1ns/100ps
`include "sram_port_regs.svh"

module ddr_sram_read_port_tb;
	logic               clk;
	logic               outRefClk;
	logic               rstn;
	logic               pllDisableN;
	logic               singleClockTie;
	logic [`ADDR_W-1:0] address;
	logic               readPortSelectN;
	logic               writePortSelectN;
	logic [1:0]         byteWriteSelectN;
	logic [`WORD_W-1:0] writeData;
	logic [`WORD_W-1:0] readDataOut;
	logic               readDataOe;
	logic               pllReady;
	logic [`ADDR_W-1:0] addrs [4];
	int                 err_total = 0;
	int                 total_checks = 0;

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		outRefClk = 1'b0;
		#7.3;
		forever #32 outRefClk = ~outRefClk;
	end

	ddr_sram_read_port ddr_sram_read_port_i (.clk(clk), .rstn(rstn), .outRefClk(outRefClk),
		.pllDisableN(pllDisableN), .singleClockTie(singleClockTie), .address(address),
		.readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN),
		.byteWriteSelectN(byteWriteSelectN), .writeData(writeData),
		.readDataOut(readDataOut), .readDataOe(readDataOe), .pllReady(pllReady));

	ctrl_model ctrl_model_i (.clk(clk), .rstn(rstn), .address(address),
		.readPortSelectN(readPortSelectN), .writePortSelectN(writePortSelectN),
		.byteWriteSelectN(byteWriteSelectN), .writeData(writeData));

	// ********
	// comparisons and report
	// ********
	task automatic checkWord(input logic [`WORD_W-1:0] got, input logic [`WORD_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t read word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic checkNum(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("FAIL %0t %s is %0d expected %0d", $time, what, got, exp);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ********
	// output watcher
	// ********
	task automatic takeWord(input int tick);
		int e;
		if (readDataOe !== 1'b1) return;
		if (ctrl_model_i.expData.size() == 0) begin
			checkNum(1, 0, "stray output word");
			return;
		end
		checkWord(readDataOut, ctrl_model_i.expData.pop_front());
		e = ctrl_model_i.expCyc.pop_front();
		if (e >= 0) checkNum(tick, e, "word cycle");
	endtask

	always @(negedge clk) if (singleClockTie) takeWord(ctrl_model_i.cyc);
	always @(negedge outRefClk) if (!singleClockTie) takeWord(0);

	// ********
	// scenario steps
	// ********
	task automatic resetTo(input logic pll, input logic single, input int hold);
		@(negedge clk);
		rstn = 1'b0;
		pllDisableN = pll;
		singleClockTie = single;
		ctrl_model_i.lat = single ? (pll ? 4 : 3) : -1;
		repeat (hold) @(negedge clk);
		rstn = 1'b1;
	endtask

	task automatic waitReady(input int lo, input int hi);
		int c;
		c = 0;
		while (pllReady !== 1'b1 && c < hi) begin
			@(negedge clk);
			c++;
		end
		checkNum(c >= lo && c < hi, 1, "ready delay");
		if (c >= hi) results();
	endtask

	// full writes, byte-masked rewrites, then reads back to back or spaced
	task automatic exercise(input int gap);
		int c;
		for (int i = 0; i < 6; i++) begin
			ctrl_model_i.step();
			if (i < 4) addrs[i] = {ctrl_model_i.seed[2:0], ctrl_model_i.seed};
			ctrl_model_i.writeBurst(addrs[i % 4], {ctrl_model_i.seed[3:0], ctrl_model_i.seed,
				~ctrl_model_i.seed}, i < 4 ? 4'h0 : ctrl_model_i.seed[7:4]);
		end
		for (int j = 0; j < 8; j++) begin
			ctrl_model_i.readBurst(addrs[(j * 3) % 4]);
			repeat (gap) @(negedge clk);
		end
		c = 0;
		while (ctrl_model_i.expData.size() != 0 && c < 2000) begin
			@(negedge clk);
			c++;
		end
		checkNum(ctrl_model_i.expData.size(), 0, "missing words");
		if (c >= 2000) results();
		repeat (40) @(negedge clk);
	endtask

	initial begin
		rstn = 1'b0;
		pllDisableN = 1'b0;
		singleClockTie = 1'b1;
		resetTo(1'b0, 1'b1, 5);
		waitReady(0, 20);
		exercise(0);
		resetTo(1'b0, 1'b0, 50);
		waitReady(0, 20);
		exercise(100);
		resetTo(1'b1, 1'b1, 50);
		waitReady(3990, 4020);
		exercise(0);
		results();
	end
endmodule
